// ==== edge_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser with rising and falling edge pulses
module edge_sync (
  input  wire logic i_clk,     // core clock
  input  wire logic i_sys_rst, // sync reset
  input  wire logic i_pin,     // asynchronous pin
  output logic      o_level,   // synchronised level
  output logic      o_rise,    // one-cycle rising pulse
  output logic      o_fall     // one-cycle falling pulse
);
  logic meta;
  logic sync;
  logic last;
  logic next_meta;
  logic next_sync;
  logic next_last;

  always_comb begin
    next_meta = i_pin;
    next_sync = meta;
    next_last = sync;
  end

  // meta is read only by sync
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      last <= next_last;
    end
  end

  assign o_level = sync;
  assign o_rise  = sync & ~last;
  assign o_fall  = ~sync & last;
endmodule // edge_sync

// ==== ext_pin_model.sv ====
`timescale 1ns/1ps
// far side: external count clock, capture pin and oscillator pin
module ext_pin_model (
  input  wire logic i_clk,       // core clock
  output logic      o_count_pin, // external count clock
  output logic      o_ccp_pin,   // capture input level
  output logic      o_osc_pin    // oscillator pin level
);
  // pins idle low; the count clock stands still between bursts
  initial begin
    o_count_pin = 1'b0;
    o_ccp_pin   = 1'b0;
    o_osc_pin   = 1'b0;
  end
  // 4 cycles high, 5 low: slow enough for the synchroniser to see every edge
  task automatic pulse_count(input int n);
    repeat (n) begin
      @(posedge i_clk) o_count_pin <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_count_pin <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask
  // each pulse gives one rising and one falling edge on the capture pin
  task automatic pulse_ccp(input int n);
    repeat (n) begin
      @(posedge i_clk) o_ccp_pin <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ccp_pin <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask
  // level on the oscillator input pin
  task automatic set_osc(input logic v);
    @(posedge i_clk) o_osc_pin <= v;
  endtask
endmodule // ext_pin_model

// ==== test_timer16_capture_compare.sv ====
`timescale 1ns/1ps
// self-checking bench for the timer and capture/compare unit
module test_timer16_capture_compare;
  logic       i_clk;
  logic       i_sys_rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] pwm_timer;
  logic [1:0] pwm_phase;
  logic       count_pin;
  logic       ccp_pin;
  logic       osc_pin;
  logic [7:0] rdata;
  logic       irq;
  logic       ccp_out;
  logic       ccp_oe_n;
  logic [1:0] osc_oe_n;
  logic       adc_start;
  int         miscompares;
  int         comparisons;
  int         adc_pulses;
  logic [7:0] v0;
  logic [7:0] v1;

  timer16_capture_compare timer16_capture_compare_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_stb), .i_rd(rd_stb),
    .i_ext_count_pin(count_pin), .i_osc_in_pin(osc_pin), .i_ccp_pin(ccp_pin), .i_pwm_timer(pwm_timer),
    .i_pwm_phase(pwm_phase), .o_rdata(rdata), .o_irq(irq), .o_ccp_out(ccp_out), .o_ccp_oe_n(ccp_oe_n),
    .o_osc_oe_n(osc_oe_n), .o_adc_start(adc_start));
  ext_pin_model ext_pin_model_i (.i_clk(i_clk), .o_count_pin(count_pin), .o_ccp_pin(ccp_pin), .o_osc_pin(osc_pin));

  // 20 MHz clock
  always #25 i_clk = ~i_clk;
  // conversion starts are counted, never cleared, so scenarios compare differences
  always @(posedge i_clk) if (adc_start === 1'b1) adc_pulses <= adc_pulses + 1;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // strobes are one cycle; the next access waits one edge so no signal is set twice
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge i_clk);
    wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge i_clk);
    rd_stb <= 1'b0;
    @(negedge i_clk);
    d = rdata;
  endtask
  task automatic read_check(input string name, input logic [7:0] a, input logic [7:0] exp);
    bus_read(a, v0);
    check(name, {8'h00, v0}, {8'h00, exp});
  endtask
  task automatic set_count(input logic [15:0] c);
    bus_write(timer16_pkg::ADDR_COUNT_HIGH, c[15:8]);
    bus_write(timer16_pkg::ADDR_COUNT_LOW, c[7:0]);
  endtask

  task automatic test_reset_values();
    check("irq", {15'h0, irq}, 16'h0000);
    check("ccp_oe_n", {15'h0, ccp_oe_n}, 16'h0001);
    check("osc_oe_n", {14'h0, osc_oe_n}, 16'h0003);
    read_check("timer_control", timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
    read_check("capture_compare_control", timer16_pkg::ADDR_CCP_CONTROL, 8'h00);
    read_check("unmapped", 8'h00, 8'h00);
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'hFF);
    read_check("timer_control mask", timer16_pkg::ADDR_TIMER_CONTROL, 8'h3F);
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
    bus_write(timer16_pkg::ADDR_CCP_CONTROL, 8'hFF);
    read_check("ccp_control mask", timer16_pkg::ADDR_CCP_CONTROL, 8'h3F);
    bus_write(timer16_pkg::ADDR_CCP_CONTROL, 8'h00);
  endtask
  // reads 128 cycles apart: ticks every 4 oscillator clocks times the prescale
  task automatic test_prescale();
    for (int ps = 3; ps >= 0; ps--) begin
      bus_write(timer16_pkg::ADDR_TIMER_CONTROL, {2'b00, ps[1:0], 4'b0001});
      bus_read(timer16_pkg::ADDR_COUNT_LOW, v0);
      repeat (126) @(posedge i_clk);
      bus_read(timer16_pkg::ADDR_COUNT_LOW, v1);
      check("ticks per 128 cycles", {8'h00, v1 - v0}, 16'(32 >> ps));
    end
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
    bus_read(timer16_pkg::ADDR_COUNT_LOW, v0);
    repeat (40) @(posedge i_clk);
    bus_read(timer16_pkg::ADDR_COUNT_LOW, v1);
    check("stopped count", {8'h00, v1}, {8'h00, v0});
  endtask
  task automatic test_overflow();
    set_count(16'hFFF0);
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'h01);
    repeat (100) @(posedge i_clk);
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
    @(negedge i_clk);
    check("masked irq", {15'h0, irq}, 16'h0000);
    read_check("wrapped high byte", timer16_pkg::ADDR_COUNT_HIGH, 8'h00);
    bus_write(timer16_pkg::ADDR_ENABLE_REG, 8'h01);
    repeat (2) @(negedge i_clk);
    check("unmasked irq", {15'h0, irq}, 16'h0001);
    read_check("overflow flag", timer16_pkg::ADDR_FLAG_REG, 8'h01);
    repeat (2) @(negedge i_clk);
    check("irq after clear", {15'h0, irq}, 16'h0000);
  endtask
  task automatic test_ext_count();
    set_count(16'h0000);
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'h03);
    ext_pin_model_i.pulse_count(5);
    repeat (8) @(posedge i_clk);
    read_check("synced edges", timer16_pkg::ADDR_COUNT_LOW, 8'h05);
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'h07);
    ext_pin_model_i.pulse_count(5);
    repeat (8) @(posedge i_clk);
    read_check("bypass edges", timer16_pkg::ADDR_COUNT_LOW, 8'h0A);
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
  endtask
  task automatic test_osc();
    bus_write(timer16_pkg::ADDR_PORT_DIR, 8'h00);
    repeat (2) @(negedge i_clk);
    check("osc pins as outputs", {14'h0, osc_oe_n}, 16'h0000);
    ext_pin_model_i.set_osc(1'b1);
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'h08);
    repeat (6) @(negedge i_clk);
    check("osc pins forced in", {14'h0, osc_oe_n}, 16'h0003);
    bus_read(timer16_pkg::ADDR_PORT_PINS, v0);
    check("osc pins read", {14'h0, v0[1:0]}, 16'h0000);
    bus_write(timer16_pkg::ADDR_TIMER_CONTROL, 8'h00);
    read_check("osc pin level", timer16_pkg::ADDR_PORT_PINS, 8'h01);
    ext_pin_model_i.set_osc(1'b0);
  endtask
  // timer stopped so the captured count is known; one edge short must not capture
  task automatic test_capture();
    int edges[4] = '{1, 1, 4, 16};
    logic [3:0] m;
    for (int k = 0; k < 4; k++) begin
      m = 4'h4 + 4'(k);
      bus_write(timer16_pkg::ADDR_CCP_CONTROL, 8'h00);
      set_count({4'h0, m, 8'hA5});
      bus_write(timer16_pkg::ADDR_CCP_CONTROL, {4'h0, m});
      bus_read(timer16_pkg::ADDR_FLAG_REG, v0);
      ext_pin_model_i.pulse_ccp(edges[k] - 1);
      repeat (6) @(posedge i_clk);
      read_check("no early capture", timer16_pkg::ADDR_FLAG_REG, 8'h00);
      ext_pin_model_i.pulse_ccp(1);
      repeat (6) @(posedge i_clk);
      read_check("capture flag", timer16_pkg::ADDR_FLAG_REG, 8'h04);
      read_check("captured low", timer16_pkg::ADDR_CCP_LOW, 8'hA5);
      read_check("captured high", timer16_pkg::ADDR_CCP_HIGH, {4'h0, m});
    end
  endtask
  task automatic test_compare();
    bus_write(timer16_pkg::ADDR_CCP_CONTROL, 8'h00);
    bus_write(timer16_pkg::ADDR_CCP_HIGH, 8'h00);
    bus_write(timer16_pkg::ADDR_CCP_LOW, 8'h10);
    set_count(16'h0000);
    bus_write(timer16_pkg::ADDR_CCP_CONTROL, 8'h08);
    bus_read(timer16_pkg::ADDR_FLAG_REG, v0);
    bus_write(timer16_pkg::ADDR_COUNT_LOW, 8'h10);
    repeat (2) @(negedge i_clk);
    check("set on match", {14'h0, ccp_oe_n, ccp_out}, 16'h0001);
    read_check("set flag", timer16_pkg::ADDR_FLAG_REG, 8'h04);
    bus_write(timer16_pkg::ADDR_CCP_CONTROL, 8'h0A);
    repeat (2) @(negedge i_clk);
    check("pin kept", {15'h0, ccp_out}, 16'h0001);
    read_check("flag only", timer16_pkg::ADDR_FLAG_REG, 8'h04);
    bus_write(timer16_pkg::ADDR_CCP_CONTROL, 8'h09);
    repeat (2) @(negedge i_clk);
    check("clear on match", {15'h0, ccp_out}, 16'h0000);
    bus_write(timer16_pkg::ADDR_ADC_ENABLE, 8'h01);
    v1 = 8'(adc_pulses);
    bus_write(timer16_pkg::ADDR_CCP_CONTROL, 8'h0B);
    repeat (4) @(negedge i_clk);
    check("conversion starts", 16'(adc_pulses) - {8'h00, v1}, 16'h0001);
    read_check("timer cleared", timer16_pkg::ADDR_COUNT_LOW, 8'h00);
    read_check("event flag", timer16_pkg::ADDR_FLAG_REG, 8'h04);
    check("pin unaffected", {15'h0, ccp_out}, 16'h0000);
  endtask
  // duty is {low byte, bits 5:4} against the separate pwm timebase
  task automatic test_pwm();
    bus_write(timer16_pkg::ADDR_CCP_LOW, 8'h40);
    bus_write(timer16_pkg::ADDR_CCP_CONTROL, 8'h1C);
    @(posedge i_clk) pwm_timer <= 8'h40;
    repeat (3) @(negedge i_clk);
    check("pwm below duty", {14'h0, ccp_oe_n, ccp_out}, 16'h0001);
    @(posedge i_clk);
    pwm_phase <= 2'b01;
    repeat (3) @(negedge i_clk);
    check("pwm at duty", {15'h0, ccp_out}, 16'h0000);
    @(posedge i_clk);
    pwm_timer <= 8'h3F;
    pwm_phase <= 2'b11;
    repeat (3) @(negedge i_clk);
    check("pwm just below", {15'h0, ccp_out}, 16'h0001);
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge i_clk);
    miscompares++;
    give_verdict();
  end
  // main sequence
  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    pwm_timer = 8'h00;
    pwm_phase = 2'b00;
    miscompares = 0;
    comparisons = 0;
    adc_pulses = 0;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    test_reset_values();
    test_prescale();
    test_overflow();
    test_ext_count();
    test_osc();
    test_capture();
    test_compare();
    test_pwm();
    give_verdict();
  end
endmodule // test_timer16_capture_compare

// ==== timer16_capture_compare.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - 16-bit count in two rw bytes, counts 0000h to FFFFh and wraps
// - overflow latches flag bit 0; irq only when enable bit 0 set
// - timer mode counts instruction cycles; counter mode counts external rising edges
// - control bit 0 set counts, clear holds the value
// - oscillator enable forces both osc pins to inputs, port reads zero
// - internal reset input lets the unit clear the count
// - unit value is low and high byte registers, own control register
// - special event match clears timer and starts conversion when converter enabled
// - capture and compare use this timer; pwm uses a separate 8-bit timer
// - modes 0100..0111 capture fall, rise, 4th, 16th rise; 0000 resets unit
// - 1000 drives pin high on match, 1001 low; both set flag
// - 1011 special event clears timer, pin unaffected, flag set
// - 11xx pwm; bits 5:4 duty lsbs, low byte duty msbs
module timer16_capture_compare (
  input  wire logic       i_clk,        // 20 MHz oscillator clock
  input  wire logic       i_sys_rst,    // sync reset, active high
  input  wire logic [7:0] i_addr,       // register address
  input  wire logic [7:0] i_wdata,      // write data
  input  wire logic       i_wr,         // write strobe
  input  wire logic       i_rd,         // read strobe
  input  wire logic       i_ext_count_pin, // external clock pin
  input  wire logic       i_osc_in_pin, // oscillator input pin
  input  wire logic       i_ccp_pin,    // capture/compare pin in
  input  wire logic [7:0] i_pwm_timer,  // separate 8-bit pwm timebase
  input  wire logic [1:0] i_pwm_phase,  // pwm timebase fine bits
  output logic [7:0]      o_rdata,      // read data, cycle after strobe
  output logic            o_irq,        // level interrupt
  output logic            o_ccp_out,    // capture/compare pin drive
  output logic            o_ccp_oe_n,   // low while pin driven
  output logic [1:0]      o_osc_oe_n,   // osc pins enables, low drives
  output logic            o_adc_start   // one-cycle conversion start
);
  logic [7:0]  timer_control, next_timer_control;
  logic [7:0]  ccp_control, next_ccp_control;
  logic [15:0] count, next_count;
  logic [15:0] ccp_value, next_ccp_value;
  logic [7:0]  flags, next_flags;
  logic [7:0]  enables, next_enables;
  logic        adc_enable, next_adc_enable;
  logic [7:0]  port_dir, next_port_dir;
  logic [1:0]  qcyc, next_qcyc;
  logic [2:0]  prescale, next_prescale;
  logic [3:0]  cap_cnt, next_cap_cnt;
  logic        pin_out, next_pin_out;
  logic        pin_drive, next_pin_drive;
  logic [7:0]  rdata, next_rdata;
  logic        irq, next_irq;
  logic        adc_start, next_adc_start;
  logic [1:0]  osc_oe_n, next_osc_oe_n;
  logic        ext_rise, ext_raw_last, next_ext_raw_last;
  logic        ccp_rise, ccp_fall;
  logic        osc_lvl;
  logic        tick_src, tick, ovf, match, cap_ev;
  logic [3:0]  mode;

  function automatic logic [2:0] ps_limit(input logic [1:0] sel);
    ps_limit = 3'((4'h1 << sel) - 4'h1);
  endfunction

  // external pin synchronised for the normal path
  edge_sync u_ext (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_ext_count_pin),
    .o_level   (),
    .o_rise    (ext_rise),
    .o_fall    ()
  );
  edge_sync u_ccp (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_ccp_pin),
    .o_level   (),
    .o_rise    (ccp_rise),
    .o_fall    (ccp_fall)
  );
  edge_sync u_osc (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_osc_in_pin),
    .o_level   (osc_lvl),
    .o_rise    (),
    .o_fall    ()
  );

  assign mode = ccp_control[3:0];

  // clock source, prescaler, count and compare
  always_comb begin
    next_qcyc = qcyc + 2'h1;
    // bypass still samples once so logic stays on one clock; saves two cycles latency
    next_ext_raw_last = i_ext_count_pin;
    if (!timer_control[timer16_pkg::TC_CS])
      tick_src = (qcyc == timer16_pkg::QCYC_LAST);
    else if (timer_control[timer16_pkg::TC_SYNC])
      tick_src = i_ext_count_pin & ~ext_raw_last;
    else
      tick_src = ext_rise;
    tick_src = tick_src & timer_control[timer16_pkg::TC_ON];
    next_prescale = prescale;
    tick = 1'b0;
    if (tick_src) begin
      if (prescale >= ps_limit(timer_control[timer16_pkg::TC_PS_HI:timer16_pkg::TC_PS_LO])) begin
        next_prescale = 3'h0;
        tick = 1'b1;
      end else begin
        next_prescale = prescale + 3'h1;
      end
    end
    ovf = tick & (count == 16'hFFFF);
    match = (count == ccp_value) && (mode[3:2] == 2'b10);
    next_count = tick ? count + 16'h1 : count;
    if (match && mode == timer16_pkg::M_CMP_SPEV)
      next_count = 16'h0000;
    if (i_wr && i_addr == timer16_pkg::ADDR_COUNT_LOW)
      next_count[7:0] = i_wdata;
    if (i_wr && i_addr == timer16_pkg::ADDR_COUNT_HIGH)
      next_count[15:8] = i_wdata;
  end

  // capture/compare unit
  always_comb begin
    next_cap_cnt = cap_cnt;
    next_ccp_value = ccp_value;
    next_pin_out = pin_out;
    next_pin_drive = pin_drive;
    next_adc_start = 1'b0;
    cap_ev = 1'b0;
    case (mode)
      timer16_pkg::M_OFF: begin
        next_cap_cnt = 4'h0;
        next_pin_out = 1'b0;
        next_pin_drive = 1'b0;
      end
      timer16_pkg::M_CAP_FALL: cap_ev = ccp_fall;
      timer16_pkg::M_CAP_RISE: cap_ev = ccp_rise;
      timer16_pkg::M_CAP_4, timer16_pkg::M_CAP_16: begin
        if (ccp_rise) begin
          if (cap_cnt == ((mode == timer16_pkg::M_CAP_4) ? timer16_pkg::CAP4_LAST : timer16_pkg::CAP16_LAST)) begin
            cap_ev = 1'b1;
            next_cap_cnt = 4'h0;
          end else begin
            next_cap_cnt = cap_cnt + 4'h1;
          end
        end
      end
      timer16_pkg::M_CMP_SET: begin
        next_pin_drive = 1'b1;
        if (match) next_pin_out = 1'b1;
      end
      timer16_pkg::M_CMP_CLR: begin
        next_pin_drive = 1'b1;
        if (match) next_pin_out = 1'b0;
      end
      timer16_pkg::M_CMP_SW: begin
        next_pin_drive = pin_drive;
      end
      timer16_pkg::M_CMP_SPEV: begin
        next_adc_start = match & adc_enable;
      end
      default: begin
        // pwm on the separate 8-bit timebase; reserved codes 0001..0011 leave the pin alone
        if (mode[3:2] == 2'b11) begin
          next_pin_drive = 1'b1;
          next_pin_out = {i_pwm_timer, i_pwm_phase} < {ccp_value[7:0], ccp_control[5:4]};
        end
      end
    endcase
    if (cap_ev)
      next_ccp_value = count;
    if (i_wr && i_addr == timer16_pkg::ADDR_CCP_LOW)
      next_ccp_value[7:0] = i_wdata;
    if (i_wr && i_addr == timer16_pkg::ADDR_CCP_HIGH)
      next_ccp_value[15:8] = i_wdata;
  end

  // register file, flags and interrupt
  always_comb begin
    next_timer_control = timer_control;
    next_ccp_control = ccp_control;
    next_enables = enables;
    next_adc_enable = adc_enable;
    next_port_dir = port_dir;
    next_flags = flags;
    next_rdata = timer16_pkg::RESET_BYTE;
    if (i_wr) begin
      case (i_addr)
        timer16_pkg::ADDR_TIMER_CONTROL: next_timer_control = i_wdata & timer16_pkg::TC_MASK;
        timer16_pkg::ADDR_CCP_CONTROL:   next_ccp_control = i_wdata & timer16_pkg::CCP_MASK;
        timer16_pkg::ADDR_ENABLE_REG:    next_enables = i_wdata & timer16_pkg::FLAG_MASK;
        timer16_pkg::ADDR_ADC_ENABLE:    next_adc_enable = i_wdata[0];
        timer16_pkg::ADDR_PORT_DIR:      next_port_dir = i_wdata;
        default: next_port_dir = port_dir;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        timer16_pkg::ADDR_TIMER_CONTROL: next_rdata = timer_control;
        timer16_pkg::ADDR_CCP_CONTROL:   next_rdata = ccp_control;
        timer16_pkg::ADDR_COUNT_LOW:     next_rdata = count[7:0];
        timer16_pkg::ADDR_COUNT_HIGH:    next_rdata = count[15:8];
        timer16_pkg::ADDR_CCP_LOW:       next_rdata = ccp_value[7:0];
        timer16_pkg::ADDR_CCP_HIGH:      next_rdata = ccp_value[15:8];
        timer16_pkg::ADDR_FLAG_REG:      next_rdata = flags;
        timer16_pkg::ADDR_ENABLE_REG:    next_rdata = enables;
        timer16_pkg::ADDR_ADC_ENABLE:    next_rdata = {7'h00, adc_enable};
        timer16_pkg::ADDR_PORT_DIR:      next_rdata = port_dir;
        // osc pins read zero while the oscillator owns them
        timer16_pkg::ADDR_PORT_PINS:
          next_rdata = timer_control[timer16_pkg::TC_OSC] ? 8'h00 : {7'h00, osc_lvl};
        default: next_rdata = timer16_pkg::RESET_BYTE;
      endcase
      // read clears the sticky flags
      if (i_addr == timer16_pkg::ADDR_FLAG_REG) next_flags = timer16_pkg::RESET_BYTE;
    end
    // set wins over the read clear
    if (ovf) next_flags[timer16_pkg::FLAG_OVF] = 1'b1;
    if (cap_ev || (match && mode != timer16_pkg::M_OFF))
      next_flags[timer16_pkg::FLAG_CCP] = 1'b1;
    next_irq = |(next_flags & next_enables);
    // direction bit 1 means input, so it is already the active-low enable
    next_osc_oe_n = timer_control[timer16_pkg::TC_OSC] ? 2'b11 : port_dir[1:0];
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      timer_control <= timer16_pkg::RESET_BYTE;
      ccp_control   <= timer16_pkg::RESET_BYTE;
      count         <= 16'h0000;
      ccp_value     <= 16'h0000;
      flags         <= timer16_pkg::RESET_BYTE;
      enables       <= timer16_pkg::RESET_BYTE;
      adc_enable    <= 1'b0;
      port_dir      <= timer16_pkg::DIR_RESET;
      qcyc          <= 2'h0;
      prescale      <= 3'h0;
      cap_cnt       <= 4'h0;
      pin_out       <= 1'b0;
      pin_drive     <= 1'b0;
      rdata         <= timer16_pkg::RESET_BYTE;
      irq           <= 1'b0;
      adc_start     <= 1'b0;
      osc_oe_n      <= 2'b11;
      ext_raw_last  <= 1'b0;
    end else begin
      timer_control <= next_timer_control;
      ccp_control   <= next_ccp_control;
      count         <= next_count;
      ccp_value     <= next_ccp_value;
      flags         <= next_flags;
      enables       <= next_enables;
      adc_enable    <= next_adc_enable;
      port_dir      <= next_port_dir;
      qcyc          <= next_qcyc;
      prescale      <= next_prescale;
      cap_cnt       <= next_cap_cnt;
      pin_out       <= next_pin_out;
      pin_drive     <= next_pin_drive;
      rdata         <= next_rdata;
      irq           <= next_irq;
      adc_start     <= next_adc_start;
      osc_oe_n      <= next_osc_oe_n;
      ext_raw_last  <= next_ext_raw_last;
    end
  end

  assign o_rdata     = rdata;
  assign o_irq       = irq;
  assign o_ccp_out   = pin_out;
  assign o_ccp_oe_n  = ~pin_drive;
  assign o_osc_oe_n  = osc_oe_n;
  assign o_adc_start = adc_start;

  a_wrap_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (tick && count == 16'hFFFF && !(match && mode == timer16_pkg::M_CMP_SPEV) && !i_wr)
    |=> (count == 16'h0000 && flags[timer16_pkg::FLAG_OVF]))
    else $error("count did not wrap with overflow flag");
  a_irq_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (flags[timer16_pkg::FLAG_OVF] && !enables[timer16_pkg::FLAG_OVF]
      && !(flags[timer16_pkg::FLAG_CCP] && enables[timer16_pkg::FLAG_CCP])) |-> !o_irq)
    else $error("irq without enable");
  a_hold_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!timer_control[timer16_pkg::TC_ON] && !i_wr && mode != timer16_pkg::M_CMP_SPEV)
    |=> $stable(count))
    else $error("count moved while stopped");
  a_osc_inputs: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    timer_control[timer16_pkg::TC_OSC] |=> o_osc_oe_n == 2'b11)
    else $error("osc pin driven while oscillator enabled");
  a_spev_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (match && mode == timer16_pkg::M_CMP_SPEV && !i_wr)
    |=> count == 16'h0000 ##0 flags[timer16_pkg::FLAG_CCP])
    else $error("special event did not clear count");
  a_adc_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_adc_start |-> $past(adc_enable) && $past(match))
    else $error("conversion start without cause");
  a_capture_copy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (cap_ev && !i_wr) |=> ccp_value == $past(count) ##0 flags[timer16_pkg::FLAG_CCP])
    else $error("capture did not copy count");
  a_cmp_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (match && mode == timer16_pkg::M_CMP_SET) |=> o_ccp_out && !o_ccp_oe_n)
    else $error("compare did not drive pin high");
  a_cmp_clr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (match && mode == timer16_pkg::M_CMP_CLR) |=> !o_ccp_out)
    else $error("compare did not drive pin low");
  a_mode_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode == timer16_pkg::M_OFF) |=> o_ccp_oe_n)
    else $error("pin driven while unit off");
endmodule // timer16_capture_compare

// ==== timer16_pkg.sv ====
package timer16_pkg;
  // register map, byte addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_CCP_CONTROL   = 8'h17;
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'h0E;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h0F;
  localparam logic [7:0] ADDR_CCP_LOW       = 8'h15;
  localparam logic [7:0] ADDR_CCP_HIGH      = 8'h16;
  localparam logic [7:0] ADDR_FLAG_REG      = 8'h0C;
  localparam logic [7:0] ADDR_ENABLE_REG    = 8'h8C;
  localparam logic [7:0] ADDR_ADC_ENABLE    = 8'h1F;
  localparam logic [7:0] ADDR_PORT_PINS     = 8'h07;
  localparam logic [7:0] ADDR_PORT_DIR      = 8'h87;
  // timer control fields
  localparam int TC_ON   = 0;
  localparam int TC_CS   = 1;
  localparam int TC_SYNC = 2;
  localparam int TC_OSC  = 3;
  localparam int TC_PS_LO = 4;
  localparam int TC_PS_HI = 5;
  localparam logic [7:0] TC_MASK  = 8'h3F;
  localparam logic [7:0] CCP_MASK = 8'h3F;
  // flag / enable bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CCP = 2;
  localparam logic [7:0] FLAG_MASK = 8'h05;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] DIR_RESET  = 8'hFF;
  // instruction cycle is four oscillator clocks
  localparam logic [1:0] QCYC_LAST = 2'h3;
  // unit modes
  typedef enum logic [3:0] {
    M_OFF      = 4'b0000,
    M_CAP_FALL = 4'b0100,
    M_CAP_RISE = 4'b0101,
    M_CAP_4    = 4'b0110,
    M_CAP_16   = 4'b0111,
    M_CMP_SET  = 4'b1000,
    M_CMP_CLR  = 4'b1001,
    M_CMP_SW   = 4'b1010,
    M_CMP_SPEV = 4'b1011
  } unit_mode_e;
  localparam logic [3:0] CAP4_LAST  = 4'h3;
  localparam logic [3:0] CAP16_LAST = 4'hF;
endpackage
